//--- gsdf_top.sv
// Sensor output path: APB registers, sample FIFO, gain stage and frame builder.
//
// Our own choice: register access over APB.
`timescale 1ns/10ps
module gsdf_top (
  input  wire logic                     clk,
  input  wire logic                     nrst,
  // APB slave.
  input  wire logic                     psel,
  input  wire logic                     penable,
  input  wire logic                     pwrite,
  input  wire logic [gsdf_pkg::ADDR_W-1:0] paddr,
  input  wire logic [31:0]              pwdata,
  output logic [31:0]                   prdata,
  output logic                          pready,
  output logic                          pslverr,
  // Compensated field samples in gauss.
  input  wire logic [15:0]              sample_data,
  input  wire logic                     sample_valid,
  output logic                          sample_ready,
  // Present temperature reading and status nibble from other logic.
  input  wire logic [11:0]              temp_data,
  input  wire logic [3:0]               status_nibble,
  // SENT frame towards the tick transmitter.
  output logic                          frame_valid,
  input  wire logic                     frame_ready,
  output logic [3:0]                    frame_status,
  output logic [23:0]                   frame_nibbles,
  output logic [2:0]                    frame_nibble_count,
  // PWM duty towards the PWM generator.
  output logic                          pwm_select,
  output logic [11:0]                   pwm_duty,
  output logic                          pwm_update
);

  // ----------------------------------------------------------------
  // Declarations.
  // ----------------------------------------------------------------
  logic [1:0]            frame_data_format;
  logic [3:0]            coarse_gain_select;
  logic [11:0]           gain_multiplier;
  logic                  output_mode;
  logic [7:0]            frame_counter;
  logic [11:0]           last_code;
  logic                  sample_ready_q;
  gsdf_pkg::gsdf_apb_t   apb_state;
  logic [7:0]            reg_idx;
  logic                  idx_hit;
  logic                  mapped;
  logic                  wr_take;
  logic                  rd_take;
  logic [31:0]           next_rdata;
  logic [15:0]           fifo_data;
  logic                  fifo_valid;
  logic                  fifo_ready;
  logic [5:0]            fifo_level;
  logic [11:0]           gain_code;
  logic                  gain_valid;
  logic                  gain_ready;
  logic                  slot_free;
  logic                  take_code;
  logic                  frame_done;
  logic [3:0]            nib1;
  logic [23:0]           next_nibbles;
  logic [2:0]            next_count;

  // ----------------------------------------------------------------
  // APB decode.
  // ----------------------------------------------------------------

  // Registers sit one per aligned word; a misaligned address is unmapped.
  assign reg_idx = paddr[9:2];
  assign idx_hit = (paddr[1:0] == 2'h0);

  always_comb begin
    mapped = 1'b0;
    if (idx_hit) begin
      case (reg_idx)
        gsdf_pkg::IDX_FORMAT: mapped = 1'b1;
        gsdf_pkg::IDX_COARSE: mapped = 1'b1;
        gsdf_pkg::IDX_MULT:   mapped = 1'b1;
        gsdf_pkg::IDX_MODE:   mapped = 1'b1;
        gsdf_pkg::IDX_STATUS: mapped = 1'b1;
        gsdf_pkg::IDX_LAST:   mapped = 1'b1;
        default:              mapped = 1'b0;
      endcase
    end
  end

  // A request is taken in its first access cycle; pready rises one cycle later.
  assign wr_take = psel && penable && !pready && pwrite && mapped;
  assign rd_take = psel && penable && !pready && !pwrite;

  // Answer state: one wait state, then a single pready cycle.
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      apb_state <= gsdf_pkg::APB_IDLE;
      pready    <= 1'b0;
      pslverr   <= 1'b0;
    end else begin
      case (apb_state)
        gsdf_pkg::APB_IDLE: begin
          if (psel && penable) begin
            apb_state <= gsdf_pkg::APB_DONE;
            pready    <= 1'b1;
            pslverr   <= !mapped;
          end else begin
            pready  <= 1'b0;
            pslverr <= 1'b0;
          end
        end
        gsdf_pkg::APB_DONE: begin
          apb_state <= gsdf_pkg::APB_IDLE;
          pready    <= 1'b0;
          pslverr   <= 1'b0;
        end
        default: begin
          apb_state <= gsdf_pkg::APB_IDLE;
          pready    <= 1'b0;
          pslverr   <= 1'b0;
        end
      endcase
    end
  end

  // ----------------------------------------------------------------
  // Configuration registers.
  // ----------------------------------------------------------------

  // Fields reset to their unprogrammed values; other bits of a word are ignored.
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      frame_data_format  <= gsdf_pkg::FMT_RST;
      coarse_gain_select <= gsdf_pkg::COARSE_RST;
      gain_multiplier    <= gsdf_pkg::MULT_RST;
      output_mode        <= gsdf_pkg::MODE_RST;
    end else if (wr_take) begin
      case (reg_idx)
        gsdf_pkg::IDX_FORMAT: begin
          frame_data_format <= pwdata[gsdf_pkg::FMT_LSB +: 2];
        end
        gsdf_pkg::IDX_COARSE: begin
          coarse_gain_select <= pwdata[gsdf_pkg::COARSE_LSB +: 4];
        end
        gsdf_pkg::IDX_MULT: begin
          gain_multiplier <= pwdata[gsdf_pkg::MULT_LSB +: 12];
        end
        gsdf_pkg::IDX_MODE: begin
          output_mode <= pwdata[gsdf_pkg::MODE_BIT];
        end
        default: begin
          output_mode <= output_mode;
        end
      endcase
    end
  end

  // Read mux; status words show the block's own state.
  always_comb begin
    next_rdata = 32'h0000_0000;
    if (idx_hit) begin
      case (reg_idx)
        gsdf_pkg::IDX_FORMAT: next_rdata[gsdf_pkg::FMT_LSB +: 2] = frame_data_format;
        gsdf_pkg::IDX_COARSE: next_rdata[gsdf_pkg::COARSE_LSB +: 4] = coarse_gain_select;
        gsdf_pkg::IDX_MULT:   next_rdata[gsdf_pkg::MULT_LSB +: 12] = gain_multiplier;
        gsdf_pkg::IDX_MODE:   next_rdata[gsdf_pkg::MODE_BIT] = output_mode;
        gsdf_pkg::IDX_STATUS: next_rdata = {18'h00000, fifo_level, frame_counter};
        gsdf_pkg::IDX_LAST:   next_rdata = {20'h00000, last_code};
        default:              next_rdata = 32'h0000_0000;
      endcase
    end
  end

  // Read data are captured with the request and held until the next read.
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      prdata <= 32'h0000_0000;
    end else if (rd_take) begin
      prdata <= next_rdata;
    end
  end

  // ----------------------------------------------------------------
  // Sample buffer and gain stage.
  // ----------------------------------------------------------------

  gsdf_fifo #(
    .WIDTH (gsdf_pkg::FIELD_W),
    .DEPTH (gsdf_pkg::FIFO_DEPTH)
  ) u_fifo (
    .clk       (clk),
    .nrst      (nrst),
    .in_data   (sample_data),
    .in_valid  (sample_valid && sample_ready_q),
    .in_ready  (),
    .out_data  (fifo_data),
    .out_valid (fifo_valid),
    .out_ready (fifo_ready),
    .level     (fifo_level)
  );

  // Ready is registered to meet the flop-output style; it lags one cycle,
  // so with a sample on every cycle it drops only as the last entry fills.
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      sample_ready_q <= 1'b0;
    end else begin
      sample_ready_q <= (fifo_level < 6'(gsdf_pkg::FIFO_DEPTH - 1));
    end
  end

  assign sample_ready = sample_ready_q;

  // Gain settings apply to samples as they leave the buffer.
  gsdf_gain_mult u_gain (
    .clk       (clk),
    .nrst      (nrst),
    .field     (signed'(fifo_data)),
    .coarse    (coarse_gain_select),
    .mult      (gain_multiplier),
    .in_valid  (fifo_valid),
    .in_ready  (fifo_ready),
    .out_code  (gain_code),
    .out_valid (gain_valid),
    .out_ready (gain_ready)
  );

  // ----------------------------------------------------------------
  // Frame builder and PWM duty.
  // ----------------------------------------------------------------

  // In SENT mode a new code is taken only once the previous frame has gone, so a slow
  // transmitter stalls the gain stage and, behind it, the buffer.
  assign frame_done = frame_valid && frame_ready;
  assign slot_free  = !frame_valid || frame_ready;
  assign gain_ready = (output_mode == gsdf_pkg::MODE_PWM) || slot_free;
  assign take_code  = gain_valid && gain_ready;
  assign nib1       = gain_code[11:8];

  // Nibble 1 is the most significant field nibble and sits in bits 23:20.
  always_comb begin
    next_nibbles = {gain_code, 12'h000};
    next_count   = gsdf_pkg::NIB_FULL;
    case (frame_data_format)
      gsdf_pkg::FMT_CNT_INV: begin
        next_nibbles = {gain_code, frame_counter + 8'(frame_done), ~nib1};
      end
      gsdf_pkg::FMT_CNT_ZERO: begin
        next_nibbles = {gain_code, frame_counter + 8'(frame_done), 4'h0};
      end
      gsdf_pkg::FMT_TEMP: begin
        next_nibbles = {gain_code, temp_data};
      end
      gsdf_pkg::FMT_SHORT: begin
        next_nibbles = {gain_code, 12'h000};
        next_count   = gsdf_pkg::NIB_SHORT;
      end
      default: begin
        next_nibbles = {gain_code, 12'h000};
        next_count   = gsdf_pkg::NIB_FULL;
      end
    endcase
  end

  // Frame register; status nibble passes through whatever the format is.
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      frame_valid        <= 1'b0;
      frame_nibbles      <= 24'h000000;
      frame_nibble_count <= gsdf_pkg::NIB_FULL;
      frame_status       <= 4'h0;
    end else if (output_mode == gsdf_pkg::MODE_SENT && take_code) begin
      frame_valid        <= 1'b1;
      frame_nibbles      <= next_nibbles;
      frame_nibble_count <= next_count;
      frame_status       <= status_nibble;
    end else if (frame_ready) begin
      frame_valid <= 1'b0;
    end
  end

  // Counter advances once per frame actually handed over.
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      frame_counter <= gsdf_pkg::CNT_RST;
    end else if (frame_done) begin
      frame_counter <= frame_counter + 8'h01;
    end
  end

  // PWM path never stalls; each code refreshes the duty with a strobe.
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      pwm_select <= gsdf_pkg::MODE_RST;
      pwm_duty   <= gsdf_pkg::OUT_MID;
      pwm_update <= 1'b0;
    end else begin
      pwm_select <= output_mode;
      pwm_update <= (output_mode == gsdf_pkg::MODE_PWM) && take_code;
      if (output_mode == gsdf_pkg::MODE_PWM && take_code) begin
        pwm_duty <= gain_code;
      end
    end
  end

  // Last output code, for software to read back.
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      last_code <= gsdf_pkg::OUT_MID;
    end else if (take_code) begin
      last_code <= gain_code;
    end
  end

endmodule

//--- gsdf_pkg.sv
// Constants, register map and lookup tables for the gain and frame data format block.
package gsdf_pkg;

  // ----------------------------------------------------------------
  // Register indices; byte address is four times the index.
  // ----------------------------------------------------------------
  localparam int            ADDR_W     = 10;
  localparam logic [7:0]    IDX_FORMAT = 8'h07;
  localparam logic [7:0]    IDX_COARSE = 8'h08;
  localparam logic [7:0]    IDX_MULT   = 8'h0a;
  localparam logic [7:0]    IDX_MODE   = 8'h1c;
  localparam logic [7:0]    IDX_STATUS = 8'h30;
  localparam logic [7:0]    IDX_LAST   = 8'h31;

  // ----------------------------------------------------------------
  // Field positions and values after reset.
  // ----------------------------------------------------------------
  localparam int            FMT_LSB    = 3;
  localparam int            COARSE_LSB = 2;
  localparam int            MULT_LSB   = 0;
  localparam int            MODE_BIT   = 3;
  localparam logic [1:0]    FMT_RST    = 2'h0;
  localparam logic [3:0]    COARSE_RST = 4'h0;
  localparam logic [11:0]   MULT_RST   = 12'h000;
  localparam logic          MODE_RST   = 1'b0;
  localparam logic [7:0]    CNT_RST    = 8'h00;

  // ----------------------------------------------------------------
  // Frame formats, nibble counts and output mode.
  // ----------------------------------------------------------------
  localparam logic [1:0]    FMT_CNT_INV  = 2'h0;
  localparam logic [1:0]    FMT_CNT_ZERO = 2'h1;
  localparam logic [1:0]    FMT_TEMP     = 2'h2;
  localparam logic [1:0]    FMT_SHORT    = 2'h3;
  localparam logic [2:0]    NIB_FULL     = 3'h6;
  localparam logic [2:0]    NIB_SHORT    = 3'h3;
  localparam logic          MODE_SENT    = 1'b0;
  localparam logic          MODE_PWM     = 1'b1;

  // ----------------------------------------------------------------
  // Data path widths, FIFO depth and gain arithmetic constants.
  // ----------------------------------------------------------------
  localparam int            FIELD_W    = 16;
  localparam int            CODE_W     = 12;
  localparam int            FIFO_DEPTH = 32;
  localparam logic [13:0]   MULT_UNITY = 14'h1000;
  localparam logic [11:0]   MULT_MAX   = 12'hfff;
  localparam logic [11:0]   OUT_MID    = 12'h800;
  localparam logic [11:0]   OUT_TOP    = 12'hfff;

  // Sensitivity in output codes per gauss, Q16 (percent/100 * 4096 * 65536).
  localparam logic [21:0] SENS_Q16 [16] = '{
    22'd268435, 22'd893890, 22'd671089, 22'd536871,
    22'd448287, 22'd335544, 22'd214748, 22'd179852,
    22'd153008, 22'd134218, 22'd107374, 22'd88584,
    22'd77846,  22'd67109,  22'd1342177, 22'd59652};

  // Sampled span in gauss, symmetric about the centre.
  localparam logic [11:0] SPAN_G [16] = '{
    12'd500,  12'd150,  12'd200,  12'd250,
    12'd300,  12'd400,  12'd625,  12'd750,
    12'd875,  12'd1000, 12'd1250, 12'd1500,
    12'd1750, 12'd2000, 12'd100,  12'd2250};

  // Bus slave answer state.
  typedef enum logic [1:0] {
    APB_IDLE = 2'b01,
    APB_DONE = 2'b10
  } gsdf_apb_t;

endpackage

//--- gsdf_fifo.sv
// Parameterised FIFO with a registered read port.
`timescale 1ns/10ps
module gsdf_fifo #(
  parameter int WIDTH = 16,
  parameter int DEPTH = 32
) (
  input  wire logic                     clk,
  input  wire logic                     nrst,
  input  wire logic [WIDTH-1:0]         in_data,
  input  wire logic                     in_valid,
  output logic                          in_ready,
  output logic [WIDTH-1:0]              out_data,
  output logic                          out_valid,
  input  wire logic                     out_ready,
  output logic [$clog2(DEPTH):0]        level
);

  localparam int AW = $clog2(DEPTH);

  logic [WIDTH-1:0] mem [DEPTH];
  logic [AW-1:0]    wptr;
  logic [AW-1:0]    rptr;
  logic [AW:0]      cnt;
  logic             push;
  logic             pop;

  // Full is taken from the storage count, so back-pressure is exact.
  assign in_ready = (cnt != AW'(0) + (AW+1)'(DEPTH));
  assign push     = in_valid && in_ready;
  assign pop      = (cnt != '0) && (!out_valid || out_ready);
  assign level    = cnt;

  // Storage array is written only; it carries no reset.
  always_ff @(posedge clk) begin
    if (push) begin
      mem[wptr] <= in_data;
    end
  end

  // Pointers and occupancy.
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      wptr <= '0;
      rptr <= '0;
      cnt  <= '0;
    end else begin
      if (push) begin
        wptr <= wptr + AW'(1);
      end
      if (pop) begin
        rptr <= rptr + AW'(1);
      end
      cnt <= cnt + (AW+1)'(push) - (AW+1)'(pop);
    end
  end

  // Read data leave through a register to keep the memory path short.
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      out_valid <= 1'b0;
      out_data  <= '0;
    end else if (pop) begin
      out_valid <= 1'b1;
      out_data  <= mem[rptr];
    end else if (out_ready) begin
      out_valid <= 1'b0;
    end
  end

endmodule

//--- gsdf_gain_mult.sv
// One-stage gain unit: span clamp, coarse sensitivity and fine multiplier.
`timescale 1ns/10ps
module gsdf_gain_mult (
  input  wire logic                            clk,
  input  wire logic                            nrst,
  input  wire logic signed [gsdf_pkg::FIELD_W-1:0] field,
  input  wire logic [3:0]                      coarse,
  input  wire logic [11:0]                     mult,
  input  wire logic                            in_valid,
  output logic                                 in_ready,
  output logic [gsdf_pkg::CODE_W-1:0]          out_code,
  output logic                                 out_valid,
  input  wire logic                            out_ready
);

  logic signed [16:0] span;
  logic signed [16:0] clamped;
  logic signed [39:0] prod1;
  logic signed [22:0] scaled;
  logic signed [14:0] mfac;
  logic signed [37:0] prod2;
  logic signed [25:0] fine;
  logic signed [25:0] code;
  logic [11:0]        next_code;

  // Input outside the selected span is held at the span edge.
  always_comb begin
    span    = 17'(signed'({5'h00, gsdf_pkg::SPAN_G[coarse]}));
    clamped = 17'(field);
    if (clamped > span) begin
      clamped = span;
    end else if (clamped < -span) begin
      clamped = -span;
    end
  end

  // Coarse sensitivity, then multiplier; top code is lifted so it doubles exactly.
  always_comb begin
    prod1  = clamped * signed'({1'b0, gsdf_pkg::SENS_Q16[coarse]});
    scaled = prod1[38:16];
    mfac   = signed'({1'b0, gsdf_pkg::MULT_UNITY + 14'(mult)
                           + 14'(mult == gsdf_pkg::MULT_MAX)});
    prod2  = scaled * mfac;
    fine   = prod2[37:12];
    code   = fine + 26'(gsdf_pkg::OUT_MID);
    if (code < 26'sd0) begin
      next_code = 12'h000;
    end else if (code > 26'(gsdf_pkg::OUT_TOP)) begin
      next_code = gsdf_pkg::OUT_TOP;
    end else begin
      next_code = code[11:0];
    end
  end

  assign in_ready = !out_valid || out_ready;

  // Result register; holds until the consumer takes it.
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      out_valid <= 1'b0;
      out_code  <= gsdf_pkg::OUT_MID;
    end else if (in_ready) begin
      out_valid <= in_valid;
      if (in_valid) begin
        out_code <= next_code;
      end
    end
  end

endmodule

//--- gsdf_top_chk.sv
// Port assertions for the gain and frame format block.
`timescale 1ns/10ps
module gsdf_top_chk (
  input wire logic        clk,
  input wire logic        nrst,
  input wire logic        psel,
  input wire logic        penable,
  input wire logic        pwrite,
  input wire logic [31:0] prdata,
  input wire logic        pready,
  input wire logic        pslverr,
  input wire logic        frame_valid,
  input wire logic        frame_ready,
  input wire logic [3:0]  frame_status,
  input wire logic [23:0] frame_nibbles,
  input wire logic [2:0]  frame_nibble_count,
  input wire logic        pwm_select,
  input wire logic        pwm_update
);
  // One clock domain, so clocking and reset are given once.
  default clocking @(posedge clk); endclocking
  default disable iff (!nrst);
  // Bus answers come one edge after the access is taken and last one cycle.
  apb_answer_a: assert property (psel && penable && !pready |=> pready ##1 !pready)
    else $error("bus answer wrong");
  err_ready_a: assert property (pslverr |-> pready)
    else $error("error without ready");
  bad_read_a: assert property (pready && pslverr && !pwrite |-> prdata == 32'h0)
    else $error("refused read not zero");
  // A held frame must not change under the receiver.
  frame_hold_a: assert property (frame_valid && !frame_ready |=> frame_valid
    && $stable(frame_nibbles) && $stable(frame_status) && $stable(frame_nibble_count))
    else $error("frame changed while held");
  nib_count_a: assert property (frame_valid |-> frame_nibble_count inside {3'h3, 3'h6})
    else $error("bad nibble count");
  short_pad_a: assert property (frame_valid && frame_nibble_count == 3'h3 |->
    frame_nibbles[11:0] == 12'h000) else $error("short frame not padded");
  // Duty updates come only in pulse width mode, where the frame path stays quiet.
  pwm_only_a: assert property (pwm_update |-> pwm_select)
    else $error("duty update outside pwm");
  pwm_quiet_a: assert property (!frame_valid ##1 pwm_select |-> !frame_valid)
    else $error("frame built in pwm");
  short_frame_c: cover property (frame_valid && frame_ready && frame_nibble_count == 3'h3);
  refused_c: cover property (pready && pslverr);
  duty_c: cover property (pwm_update);
endmodule

bind gsdf_top gsdf_top_chk gsdf_top_chk_inst (.clk(clk), .nrst(nrst), .psel(psel),
  .penable(penable), .pwrite(pwrite), .prdata(prdata), .pready(pready), .pslverr(pslverr),
  .frame_valid(frame_valid), .frame_ready(frame_ready), .frame_status(frame_status),
  .frame_nibbles(frame_nibbles), .frame_nibble_count(frame_nibble_count),
  .pwm_select(pwm_select), .pwm_update(pwm_update));

//--- gsdf_rx.sv
// Receiver model at the far side of the frame interface.
`timescale 1ns/10ps
module gsdf_rx (
  input  wire logic        clk,
  input  wire logic        nrst,
  input  wire logic [1:0]  mode,
  input  wire logic        frame_valid,
  output logic             frame_ready,
  input  wire logic [3:0]  frame_status,
  input  wire logic [23:0] frame_nibbles,
  input  wire logic [2:0]  frame_nibble_count
);
  logic [30:0] q[$];
  // Mode 0 takes every frame, mode 1 on each edge with a chance of one in four, mode 2 stalls.
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) frame_ready <= 1'b0;
    else frame_ready <= (mode == 2'h0) || (mode == 2'h1 && $urandom_range(3) == 0);
  end
  // The count travels with each frame, so parsing follows the set format.
  always_ff @(posedge clk) begin
    if (frame_valid && frame_ready) q.push_back({frame_status, frame_nibble_count, frame_nibbles});
  end
endmodule

//--- tb.sv
// Self-checking testbench for the gain and frame data format block.
`timescale 1ns/10ps
module tb;
  logic        clk = 1'b0, nrst = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
  logic        sample_valid = 1'b0;
  logic [9:0]  paddr = 10'h000;
  logic [31:0] pwdata = 32'h0, prdata, rd, wv[4];
  logic [15:0] sample_data = 16'h0;
  logic [11:0] temp_data = 12'h0, pwm_duty, mult = 12'h0;
  logic [3:0]  status_nibble = 4'h0, frame_status, coarse = 4'h0;
  logic [1:0]  rx_mode = 2'h0, fmt = 2'h0;
  logic        pready, pslverr, sample_ready, frame_valid, frame_ready, err;
  logic        pwm_select, pwm_update;
  logic [23:0] frame_nibbles;
  logic [2:0]  frame_nibble_count;
  logic [7:0]  cnt = 8'h0;
  logic [30:0] e;
  logic [15:0] sent[$];
  int          num_errors = 0, tests_run = 0, n, i, t;
  logic [9:0]  addrs[4] = '{10'h01c, 10'h020, 10'h028, 10'h070};
  logic [31:0] masks[4] = '{32'h18, 32'h3c, 32'hfff, 32'h8};

  always #20 clk = ~clk;

  gsdf_top gsdf_top_inst (.clk(clk), .nrst(nrst), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .sample_data(sample_data), .sample_valid(sample_valid),
    .sample_ready(sample_ready), .temp_data(temp_data), .status_nibble(status_nibble),
    .frame_valid(frame_valid), .frame_ready(frame_ready), .frame_status(frame_status),
    .frame_nibbles(frame_nibbles), .frame_nibble_count(frame_nibble_count),
    .pwm_select(pwm_select), .pwm_duty(pwm_duty), .pwm_update(pwm_update));
  gsdf_rx gsdf_rx_inst (.clk(clk), .nrst(nrst), .mode(rx_mode), .frame_valid(frame_valid),
    .frame_ready(frame_ready), .frame_status(frame_status), .frame_nibbles(frame_nibbles),
    .frame_nibble_count(frame_nibble_count));

  // Expected frame from the gain path and the format now in force.
  function automatic logic [30:0] exp_frame(input logic [15:0] s);
    longint f, sp, p, m, c;
    logic [23:0] nb;
    f = longint'($signed(s));
    sp = gsdf_pkg::SPAN_G[coarse];
    f = (f > sp) ? sp : ((f < -sp) ? -sp : f);
    p = (f * longint'(gsdf_pkg::SENS_Q16[coarse])) >>> 16;
    m = 4096 + longint'(mult) + longint'(mult == 12'hfff);
    c = 2048 + ((p * m) >>> 12);
    c = (c < 0) ? 0 : ((c > 4095) ? 4095 : c);
    case (fmt)
      2'h0: nb = {c[11:0], cnt, ~c[11:8]};
      2'h1: nb = {c[11:0], cnt, 4'h0};
      2'h2: nb = {c[11:0], temp_data};
      default: nb = {c[11:0], 12'h000};
    endcase
    return {status_nibble, (fmt == 2'h3) ? 3'h3 : 3'h6, nb};
  endfunction

  // Compares one value; a mismatch is reported at once and counted.
  task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    tests_run++;
    if (seen !== exp) begin
      num_errors++;
      $display("Error %s: expected %h seen %h", nm, exp, seen);
    end
  endtask

  // One bus transfer; the request stands until pready is seen at an edge.
  task automatic apb(input logic w, input logic [9:0] a, input logic [31:0] d);
    int k;
    k = 0;
    @(posedge clk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    penable <= 1'b1;
    do begin
      @(posedge clk);
      k++;
    end while (pready !== 1'b1 && k < 50);
    rd = prdata;
    err = pslverr;
    if (k >= 50) num_errors++;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  // Offers one sample; it is recorded only if the block takes it in time.
  task automatic push(input logic [15:0] s, input int lim);
    n = 0;
    @(posedge clk);
    sample_data <= s;
    sample_valid <= 1'b1;
    do begin
      @(posedge clk);
      n++;
    end while (sample_ready !== 1'b1 && n < lim);
    sample_valid <= 1'b0;
    if (sample_ready === 1'b1) sent.push_back(s);
  endtask

  // Takes every outstanding frame and compares them in order.
  task automatic drain();
    while (sent.size() > 0) begin
      n = 0;
      while (gsdf_rx_inst.q.size() == 0 && n < 400) begin
        @(posedge clk);
        n++;
      end
      if (n >= 400) begin
        chk("frame arrival", 32'h0, 32'h1);
        return;
      end
      chk("frame", 32'(gsdf_rx_inst.q.pop_front()), 32'(exp_frame(sent.pop_front())));
      cnt++;
    end
  endtask

  // Ends the run with the counts and the verdict.
  task automatic finish_test();
    $display("Checks %0d, mismatches %0d", tests_run, num_errors);
    if (num_errors == 0 && tests_run > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask

  // A hang is cut short well beyond the expected run length.
  initial begin
    #(40 * 40000);
    num_errors++;
    finish_test();
  end

  // Reset values, readback, a second reset, all formats, buffer fill, then PWM.
  initial begin
    n = $urandom(32'hff8bfc86);
    repeat (20) @(posedge clk);
    nrst <= 1'b1;
    for (i = 0; i < 12; i++) begin
      apb(1'b0, addrs[i % 4], 32'h0);
      chk("register", rd, (i < 4) ? 32'h0 : wv[i % 4]);
      t = $urandom;
      wv[i % 4] = 32'(t) & masks[i % 4];
      apb(1'b1, addrs[i % 4], 32'(t));
    end
    apb(1'b0, 10'h3fc, 32'h0);
    chk("unmapped", {err, rd[30:0]}, 32'h80000000);
    nrst <= 1'b0;
    repeat (2) @(posedge clk);
    nrst <= 1'b1;
    for (t = 0; t < 8; t++) begin
      fmt = 2'(t % 4);
      rx_mode <= 2'(t % 2);
      if (t > 0) begin
        coarse = (t == 1) ? 4'h3 : 4'($urandom);
        mult = (t == 1) ? 12'hfff : 12'($urandom);
        temp_data <= 12'($urandom);
        status_nibble <= 4'($urandom);
        apb(1'b1, 10'h020, {26'h0, coarse, 2'h0});
        apb(1'b1, 10'h028, {20'h0, mult});
      end
      apb(1'b1, 10'h01c, {27'h0, fmt, 3'h0});
      for (i = 0; i < 36; i++) push((i < 2) ? 16'h8000 - 16'(i) : 16'($urandom_range(6000) - 3000), 300);
      drain();
      apb(1'b0, 10'h0c0, 32'h0);
      chk("frame counter", rd, {24'h0, cnt});
      $display("Test %0d done, format %0d", t, fmt);
    end
    rx_mode <= 2'h2;
    n = 0;
    for (i = 0; i < 40 && n < 20; i++) push(16'($urandom_range(400)), 20);
    chk("fifo refusal", {31'h0, sent.size() == 34 && n >= 20}, 32'h1);
    rx_mode <= 2'h1;
    drain();
    $display("Test fill done");
    apb(1'b1, 10'h070, 32'h8);
    push(16'h0123, 300);
    n = 0;
    while (pwm_update !== 1'b1 && n < 100) begin
      @(posedge clk);
      n++;
    end
    e = exp_frame(sent.pop_front());
    chk("pwm duty", {19'h0, pwm_select, pwm_duty}, {19'h0, 1'b1, e[23:12]});
    chk("pwm frames", 32'(gsdf_rx_inst.q.size()), 32'h0);
    apb(1'b0, 10'h0c4, 32'h0);
    chk("last code", rd, {20'h0, e[23:12]});
    apb(1'b1, 10'h070, 32'h0);
    push(16'hff00, 300);
    drain();
    $display("Test pwm done");
    finish_test();
  end
endmodule
